// file: tb/eews_array_model.sv
// Array side model: latch index scan and raw read data
`timescale 1ns/10ps
module eews_array_model
(
  // Clock and reset
  input wire        mclk,
  input wire        rst,
  // Cycle state
  input wire        ee_busy,
  // Array signals
  output reg [15:0] ee_rd_raw = 16'h3c00,
  output reg [3:0]  ee_lat_idx = 4'h0
);
  // Scan one latch a cycle; read data keeps changing while a cycle runs
  always @(posedge mclk)
  begin
    ee_lat_idx <= rst ? 4'h0 : ee_lat_idx + 4'h1;
    ee_rd_raw  <= ee_busy ? ~ee_rd_raw : 16'h3c00;
  end
endmodule

// file: tb/eews_props.sv
// Port assertions for the data EEPROM write sequencer
`timescale 1ns/10ps
module eews_props
#(
  parameter PGM_CYCLES = 20
)
(
  // Clock and reset
  input wire        mclk,
  input wire        rst,
  // Register writes
  input wire [11:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire        reg_wr,
  // Reset events and power-up timer
  input wire        ext_reset_evt,
  input wire        wdt_reset_evt,
  input wire        pwrt_running,
  // Cycle outputs
  input wire        ee_commit,
  input wire [23:0] ee_addr,
  input wire        ee_busy,
  input wire        cycle_done_flag
);
  // Longest a finished cycle may have been busy: the count plus hand-off
  localparam int MAXB = PGM_CYCLES + 2;
  // Clocks the current cycle has been busy so far
  int busy_len = 0;
  always @(posedge mclk)
  begin
    busy_len <= ee_busy ? busy_len + 1 : 0;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Control and status writes
  wire ctl_wr = reg_wr && reg_addr == 12'h760;
  wire clr_wr = reg_wr && reg_addr == 12'h768 && reg_wdata[0];
  property p_start_src; !ee_busy && !ctl_wr |=> !ee_busy; endproperty
  a_start_src: assert property (p_start_src) else $error("cycle began without control write");
  property p_set_only; !ee_busy && ctl_wr && !reg_wdata[15] |=> !ee_busy; endproperty
  a_set_only: assert property (p_set_only) else $error("cycle began with start bit low");
  property p_pwrt; pwrt_running && !ee_busy |=> !ee_busy; endproperty
  a_pwrt: assert property (p_pwrt) else $error("cycle began under power-up timer");
  property p_end; $fell(ee_busy) && !$past(ext_reset_evt) && !$past(wdt_reset_evt) |-> cycle_done_flag && ee_commit;
  endproperty
  a_end: assert property (p_end) else $error("cycle end without done flag and commit");
  property p_pulse; ee_commit |=> !ee_commit; endproperty
  a_pulse: assert property (p_pulse) else $error("commit longer than one cycle");
  property p_held; cycle_done_flag && !clr_wr |=> cycle_done_flag; endproperty
  a_held: assert property (p_held) else $error("done flag dropped by itself");
  property p_abort; ee_busy && (ext_reset_evt || wdt_reset_evt) |=> !ee_busy && !ee_commit && $stable(ee_addr);
  endproperty
  a_abort: assert property (p_abort) else $error("abort mishandled");
  property p_keep; ee_busy && ctl_wr && !reg_wdata[14] && !ext_reset_evt && !wdt_reset_evt |=> ee_busy || ee_commit;
  endproperty
  a_keep: assert property (p_keep) else $error("clearing enable stopped cycle");
  property p_len; $fell(ee_busy) && !$past(ext_reset_evt) && !$past(wdt_reset_evt)
    |-> busy_len >= PGM_CYCLES && busy_len <= MAXB; endproperty
  a_len: assert property (p_len) else $error("cycle length wrong");
endmodule
bind eews_top eews_props #(.PGM_CYCLES(PGM_CYCLES)) props_u (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .ext_reset_evt(ext_reset_evt), .wdt_reset_evt(wdt_reset_evt),
  .pwrt_running(pwrt_running), .ee_commit(ee_commit), .ee_addr(ee_addr), .ee_busy(ee_busy),
  .cycle_done_flag(cycle_done_flag));

// file: tb/eews_top_tb.sv
// Self-checking bench for the data EEPROM write sequencer
`timescale 1ns/10ps
`include "eews_regs.vh"
module eews_top_tb;
  // Register addresses
  localparam [23:0] CT = {12'h000, `EEWS_OFS_CTRL};
  localparam [23:0] KY = {12'h000, `EEWS_OFS_KEY};
  localparam [23:0] ST = {12'h000, `EEWS_OFS_STATUS};
  // Stimulus
  reg         mclk = 1'b0;
  reg         rst = 1'b1;
  reg  [11:0] reg_addr = 12'h000;
  reg  [15:0] reg_wdata = 16'h0000;
  reg         reg_wr = 1'b0;
  reg         reg_rd = 1'b0;
  reg         tw_strobe = 1'b0;
  reg  [23:0] tw_addr = 24'h000000;
  reg  [15:0] tw_data = 16'h0000;
  reg         ext_reset_evt = 1'b0;
  reg         wdt_reset_evt = 1'b0;
  reg         pwrt_running = 1'b0;
  // Observed
  wire [15:0] reg_rdata, tr_data, ee_rd_raw, ee_lat_data;
  wire [6:0]  ee_op;
  wire [23:0] ee_addr;
  wire [3:0]  ee_lat_idx;
  wire        ee_commit, ee_busy, cycle_done_flag;
  integer     errors = 0;
  integer     compares = 0;
  integer     k, i, n;
  reg  [6:0]  op;
  // 8 ns clock
  always #4 mclk = ~mclk;
  eews_top #(.PGM_CYCLES(20)) dut_u (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tw_strobe(tw_strobe), .tw_addr(tw_addr),
    .tw_data(tw_data), .ee_rd_raw(ee_rd_raw), .tr_data(tr_data), .ext_reset_evt(ext_reset_evt),
    .wdt_reset_evt(wdt_reset_evt), .pwrt_running(pwrt_running), .ee_commit(ee_commit), .ee_op(ee_op),
    .ee_addr(ee_addr), .ee_lat_idx(ee_lat_idx), .ee_lat_data(ee_lat_data), .ee_busy(ee_busy),
    .cycle_done_flag(cycle_done_flag));
  eews_array_model model_u (.mclk(mclk), .rst(rst), .ee_busy(ee_busy), .ee_rd_raw(ee_rd_raw),
    .ee_lat_idx(ee_lat_idx));
  // Verdict and end of run
  task close_out;
  begin
    if (errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask
  // Compare and count
  task chk(input [23:0] s, input [23:0] e);
  begin
    compares = compares + 1;
    if (s !== e)
    begin
      errors = errors + 1;
      $display("ERROR %0t: saw %h want %h", $time, s, e);
    end
  end
  endtask
  // One cycle from a rising edge: 0 idle, 1 write, 2 read, 3 table write
  task bus(input [1:0] t, input [23:0] a, input [15:0] d);
  begin
    @(posedge mclk);
    reg_wr <= t == 2'd1;
    reg_rd <= t == 2'd2;
    tw_strobe <= t == 2'd3;
    reg_addr <= a[11:0];
    tw_addr <= a;
    reg_wdata <= d;
    tw_data <= d;
  end
  endtask
  // Read; data stands only in the next cycle
  task rd(input [23:0] a, input [15:0] e);
  begin
    bus(2'd2, a, 16'h0000);
    bus(2'd0, 24'h0, 16'h0);
    #1 chk(reg_rdata, e);
  end
  endtask
  // Control, two keys, control again, then look at busy
  task go(input [15:0] p, input [7:0] k1, input [7:0] k2, input [15:0] f, input b);
  begin
    bus(2'd1, CT, p);
    bus(2'd1, KY, {8'h00, k1});
    bus(2'd1, KY, {8'h00, k2});
    bus(2'd1, CT, f);
    bus(2'd0, 24'h0, 16'h0);
    #1 chk(ee_busy, b);
  end
  endtask
  // Bounded wait for the commit pulse
  task wt;
  begin
    n = 0;
    while (ee_commit !== 1'b1 && n < 60)
    begin
      @(posedge mclk);
      #1 n = n + 1;
    end
    if (ee_commit !== 1'b1)
    begin
      chk(24'h1, 24'h0);
      close_out;
    end
  end
  endtask
  // Main sequence
  initial
  begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    rd(CT, 16'h0000);
    rd(ST, 16'h0000);
    rd(24'h000770, 16'h0000);
    go(16'h0004, 8'h55, 8'haa, 16'h8004, 1'b0);
    go(16'h0004, 8'h55, 8'haa, 16'hc004, 1'b0);
    go(16'h4004, 8'h55, 8'haa, 16'h4004, 1'b0);
    bus(2'd1, CT, 16'hc004);
    bus(2'd0, 24'h0, 16'h0);
    #1 chk(ee_busy, 1'b0);
    go(16'h4004, 8'h55, 8'h11, 16'hc004, 1'b0);
    go(16'h4004, 8'haa, 8'h55, 16'hc004, 1'b0);
    go(16'h4001, 8'h55, 8'haa, 16'hc001, 1'b0);
    @(posedge mclk);
    pwrt_running <= 1'b1;
    go(16'h4004, 8'h55, 8'haa, 16'hc004, 1'b0);
    @(posedge mclk);
    pwrt_running <= 1'b0;
    // Every operation code, sixteen latches loaded first
    for (k = 0; k < 4; k = k + 1)
    begin
      op = k == 0 ? 7'h04 : k == 1 ? 7'h0a : k == 2 ? 7'h44 : 7'h45;
      for (i = 0; i < 16; i = i + 1)
        bus(2'd3, {19'h3ffe2, i[3:0], 1'b0}, {12'hb00, i[3:0]});
      go({9'h080, op}, 8'h55, 8'haa, {9'h180, op}, 1'b1);
      chk(ee_op, op);
      chk(ee_addr, op[0] | op[3] ? 24'h7ffc40 : 24'h7ffc5e);
      bus(2'd1, CT, {1'b0, k != 1, 7'h00, op});
      bus(2'd0, 24'h0, 16'h0);
      #1 chk(ee_busy, 1'b1);
      chk(tr_data, 16'hffff);
      rd(ST, 16'h0002);
      wt;
      chk(cycle_done_flag, 1'b1);
      rd(CT, {1'b0, k != 1, 7'h00, op});
      chk(tr_data, 16'h3c00);
      bus(2'd1, CT, {9'h180, op});
      bus(2'd0, 24'h0, 16'h0);
      #1 chk(ee_busy, 1'b0);
      chk(cycle_done_flag, 1'b1);
      bus(2'd1, ST, 16'h0001);
      rd(ST, 16'h0000);
    end
    // Latch contents, one cycle after the index
    for (i = 0; i < 16; i = i + 1)
    begin
      @(posedge mclk);
      #1 n = ee_lat_idx;
      @(posedge mclk);
      #1 chk(ee_lat_data, {12'hb00, n[3:0]});
    end
    // External then watchdog reset during a cycle
    for (k = 0; k < 2; k = k + 1)
    begin
      bus(2'd3, 24'h7ffc46, 16'h00a5);
      go(16'h4004, 8'h55, 8'haa, 16'hc004, 1'b1);
      repeat (9) @(posedge mclk);
      ext_reset_evt <= k == 0;
      wdt_reset_evt <= k == 1;
      @(posedge mclk);
      ext_reset_evt <= 1'b0;
      wdt_reset_evt <= 1'b0;
      bus(2'd0, 24'h0, 16'h0);
      #1 chk(ee_busy, 1'b0);
      chk(ee_addr, 24'h7ffc46);
      rd(CT, 16'h6004);
      rd(ST, 16'h0000);
      bus(2'd1, CT, 16'h0004);
    end
    // Target address kept through both aborts
    rd({12'h000, `EEWS_OFS_ADDR_LO}, 16'hfc46);
    rd({12'h000, `EEWS_OFS_ADDR_HI}, 16'h007f);
    close_out;
  end
endmodule

// file: verilog/eews_regs.vh
// Constants for the data EEPROM write sequencer
`ifndef EEWS_REGS_VH
`define EEWS_REGS_VH

// Register offsets
`define EEWS_OFS_CTRL    12'h760
`define EEWS_OFS_ADDR_LO 12'h762
`define EEWS_OFS_ADDR_HI 12'h764
`define EEWS_OFS_KEY     12'h766
`define EEWS_OFS_STATUS  12'h768

// Control register fields
`define EEWS_CTRL_START  15
`define EEWS_CTRL_PROGRAM_ENABLE_BIT   14
`define EEWS_CTRL_ABORT  13
`define EEWS_CTRL_TWRI   12
`define EEWS_CTRL_OP_HI  6
`define EEWS_CTRL_OP_LO  0
`define EEWS_CTRL_RST    16'h0000

// Operation codes in the control low bits
`define EEWS_OP_WORD_PGM 7'h04
`define EEWS_OP_BLK_PGM  7'h0a
`define EEWS_OP_WORD_ERS 7'h44
`define EEWS_OP_BLK_ERS  7'h45

// Unlock key values
`define EEWS_KEY_FIRST   8'h55
`define EEWS_KEY_SECOND  8'haa

// Status register fields
`define EEWS_STAT_DONE   0
`define EEWS_STAT_BUSY   1

// Filler returned for reads during a cycle
`define EEWS_RD_JUNK     16'hffff

// Timing
`define EEWS_CLK_PS      8000
`define EEWS_PGM_TIME_US 2000
`define EEWS_PGM_CYCLES  ((`EEWS_PGM_TIME_US * 1000000) / `EEWS_CLK_PS)

`endif

// file: verilog/eews_timer.v
// Program/erase cycle duration timer
`timescale 1ns/10ps
module eews_timer
#(
  parameter CNT_W  = 18,
  parameter CYCLES = 250000
)
(
  // Clock and reset
  input  wire mclk,
  input  wire rst,
  // Control
  input  wire start,
  input  wire abort,
  // Status
  output reg  busy,
  output reg  done
);

  localparam integer     LAST_I = CYCLES - 1;           // Final count, full width
  localparam [CNT_W-1:0] LAST   = LAST_I[CNT_W-1:0];   // Final count value

  reg [CNT_W-1:0] count; // Cycles elapsed in this cycle

  // Count runs free of the bus, so the processor never stalls
  always @(posedge mclk)
  begin
    if (rst)
    begin
      busy  <= 1'b0;
      done  <= 1'b0;
      count <= {CNT_W{1'b0}};
    end
    else
    begin
      done <= 1'b0;
      if (abort)
      begin
        busy  <= 1'b0;
        count <= {CNT_W{1'b0}};
      end
      else if (start && !busy)
      begin
        busy  <= 1'b1;
        count <= {CNT_W{1'b0}};
      end
      else if (busy)
      begin
        if (count == LAST)
        begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        else
          count <= count + 1'b1;
      end
    end
  end

endmodule

// file: verilog/eews_top.v
// Data EEPROM write sequencer: registers, latches and cycle control
//
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`include "eews_regs.vh"
module eews_top
#(
  // Program or erase time in clocks; shorten it for simulation only
  parameter PGM_CYCLES = `EEWS_PGM_CYCLES,
  // Width of the cycle counter; must hold PGM_CYCLES - 1
  parameter CNT_W      = 18,
  // Write latches in one block
  parameter LATCHES    = 16
)
(
  // Clock and power-on reset
  input  wire        mclk,
  input  wire        rst,
  // Register port
  input  wire [11:0] reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata,
  // Table write port
  input  wire        tw_strobe,
  input  wire [23:0] tw_addr,
  input  wire [15:0] tw_data,
  // Table read port
  input  wire [15:0] ee_rd_raw,
  output reg  [15:0] tr_data,
  // Reset events and power-up timer
  input  wire        ext_reset_evt,
  input  wire        wdt_reset_evt,
  input  wire        pwrt_running,
  // Array control
  output reg         ee_commit,
  output reg  [6:0]  ee_op,
  output reg  [23:0] ee_addr,
  input  wire [3:0]  ee_lat_idx,
  output reg  [15:0] ee_lat_data,
  // Status
  output wire        ee_busy,
  output wire        cycle_done_flag
);

  // Storage. Everything below runs on every clock; there is no enable.
  // Control register fields
  reg        start_bit;          // Cycle start, set-only
  reg        program_enable_bit; // Write enable
  reg        cycle_abort_flag;   // Cycle interrupted by reset
  reg        twri_bit;           // Spare control bit, stored only
  reg [6:0]  op_code;            // Selected operation
  reg [15:0] target_addr_low;    // Target address bits 15:0
  reg [7:0]  target_addr_high;   // Target address bits 23:16
  reg        done_flag;          // Completion flag
  reg [15:0] latch_mem [0:LATCHES-1]; // Write latches

  // Internal strobes and engine status
  wire       armed;      // Unlock sequence complete
  wire       tmr_busy;   // Timer running
  wire       tmr_done;   // Timer finished, one cycle
  wire       abort_evt;  // External or watchdog reset event
  wire       ctrl_wr;    // Write to control register
  wire       key_wr;     // Write to key register
  wire       status_wr;  // Write to status register
  wire       op_ok;      // Operation code is a data EEPROM op
  wire       start_req;  // Start accepted this cycle
  wire [15:0] ctrl_val;  // Control register read value

  // Bus decodes. The slave never stalls the master, so each decode is a
  // one-cycle strobe that is acted on at the edge that samples it.
  // Either reset event aborts a running cycle by clearing the start bit; the
  // power-on reset is the only reset that clears the other registers below.
  assign abort_evt = ext_reset_evt | wdt_reset_evt;
  assign ctrl_wr   = reg_wr && (reg_addr == `EEWS_OFS_CTRL);
  assign key_wr    = reg_wr && (reg_addr == `EEWS_OFS_KEY);
  assign status_wr = reg_wr && (reg_addr == `EEWS_OFS_STATUS);
  assign ee_busy   = start_bit;
  assign cycle_done_flag = done_flag;

  // Only the four data EEPROM operations may run. Any other code leaves
  // the engine idle; the start write is still a control write, so the
  // unlock is spent and software must repeat the key sequence once the
  // operation field has been put right.
  assign op_ok = (op_code == `EEWS_OP_WORD_PGM) ||
                 (op_code == `EEWS_OP_BLK_PGM)  ||
                 (op_code == `EEWS_OP_WORD_ERS) ||
                 (op_code == `EEWS_OP_BLK_ERS);

  // Start needs the unlock, an enable stored by an earlier write, an idle
  // engine and an expired power-up timer. The enable is the stored value,
  // so a write setting both bits at once is refused.
  // A reset event in the same cycle wins over the start, and a start
  // while the engine already runs is dropped rather than queued: the
  // start bit is set-only, so software could not cancel a queued start.
  // The power-up timer arrives as a level and blocks starts throughout.
  assign start_req = ctrl_wr && reg_wdata[`EEWS_CTRL_START]
                     && armed
                     && program_enable_bit
                     && !pwrt_running
                     && !start_bit && op_ok && !abort_evt;

  // Control read value; bits 11:7 read as zero
  assign ctrl_val = {start_bit, program_enable_bit, cycle_abort_flag, twri_bit,
                     5'h00, op_code};

  // Key sequence tracker. It sees the raw key and control strobes, so a
  // control write that is refused still spends the unlock; this keeps a
  // runaway loop from retrying starts on one key sequence.
  eews_unlock u_unlock
  (
    .mclk     (mclk),
    .rst      (rst),
    .key_wr   (key_wr),
    .key_data (reg_wdata[7:0]),
    .ctrl_wr  (ctrl_wr),
    .armed    (armed)
  );

  // Cycle duration timer. It runs beside the register port, so software
  // keeps executing and can poll the status register while it counts.
  // A start while the timer is busy is ignored there as well.
  eews_timer
  #(
    .CNT_W  (CNT_W),
    .CYCLES (PGM_CYCLES)
  )
  u_timer
  (
    .mclk  (mclk),
    .rst   (rst),
    .start (start_req),
    .abort (abort_evt),
    .busy  (tmr_busy),
    .done  (tmr_done)
  );

  // Control register; power-on reset clears everything. The reset events
  // clear only the start bit: software reads the abort flag after such a reset to
  // learn that the location must be written again.
  always @(posedge mclk)
  begin
    if (rst)
    begin
      start_bit          <= 1'b0;
      program_enable_bit <= 1'b0;
      cycle_abort_flag   <= 1'b0;
      twri_bit           <= 1'b0;
      op_code            <= 7'h00;
    end
    else
    begin
      // Enable follows software only, even mid-cycle
      // Dropping it mid-cycle cannot stop the cycle, which never reads it again
      if (ctrl_wr)
        program_enable_bit <= reg_wdata[`EEWS_CTRL_PROGRAM_ENABLE_BIT];
      if (ctrl_wr)
        twri_bit <= reg_wdata[`EEWS_CTRL_TWRI];
      // Operation is frozen while a cycle runs
      // so a mid-cycle write cannot change what is committed
      if (ctrl_wr && !start_bit)
        op_code <= reg_wdata[`EEWS_CTRL_OP_HI:`EEWS_CTRL_OP_LO];
      // Start bit: set by accepted start, cleared only by hardware
      // A written zero has no effect, so software cannot end a cycle early
      if (start_req)
        start_bit <= 1'b1;
      else if (tmr_done || abort_evt)
        start_bit <= 1'b0;
      // Error flag: set on interrupted cycle wins over software write
      // Software may clear it by writing zero once it has redone the word
      if (abort_evt && start_bit)
        cycle_abort_flag <= 1'b1;
      else if (ctrl_wr)
        cycle_abort_flag <= reg_wdata[`EEWS_CTRL_ABORT];
    end
  end

  // Completion flag; a set in the clearing cycle wins, so a finish is
  // never lost to a late clear. A reset event that lands on the final
  // cycle turns the finish into an abort, so no flag is raised then.
  always @(posedge mclk)
  begin
    if (rst)
      done_flag <= 1'b0;
    else if (tmr_done && !abort_evt)
      done_flag <= 1'b1;
    else if (status_wr && reg_wdata[`EEWS_STAT_DONE])
      done_flag <= 1'b0;
  end

  // Target address: software writes or capture of last table write.
  // An abort leaves the address untouched so the location can be redone.
  // A table write wins over a register write in the same cycle, and
  // register writes are ignored while a cycle runs, though table writes still move the target.
  always @(posedge mclk)
  begin
    if (rst)
    begin
      target_addr_low  <= 16'h0000;
      target_addr_high <= 8'h00;
    end
    // Capture of the most recent table write
    else if (tw_strobe)
    begin
      target_addr_low  <= tw_addr[15:0];
      target_addr_high <= tw_addr[23:16];
    end
    // Direct register writes while idle
    else if (reg_wr && !start_bit)
    begin
      if (reg_addr == `EEWS_OFS_ADDR_LO)
        target_addr_low <= reg_wdata;
      if (reg_addr == `EEWS_OFS_ADDR_HI)
        target_addr_high <= reg_wdata[7:0];
    end
  end

  // Write latches, one per word of a block, indexed by word address
  // A word program uses only the latch of its own address; the others
  // keep stale data, which is harmless since they are not committed.
  genvar gi;
  generate
    for (gi = 0; gi < LATCHES; gi = gi + 1)
    begin : g_latch
      always @(posedge mclk)
      begin
        if (rst)
          latch_mem[gi] <= 16'h0000;
        else if (tw_strobe && (tw_addr[4:1] == gi))
          latch_mem[gi] <= tw_data;
      end
    end
  endgenerate

  // Array hand-off: commit at the end of the cycle with the captured
  // address; a block op covers all sixteen latches in one go
  // The latch read port is free-running so the array can scan the
  // latches at its own pace during the commit; the data trail the index
  // by one clock.
  always @(posedge mclk)
  begin
    if (rst)
    begin
      ee_commit   <= 1'b0;
      ee_op       <= 7'h00;
      ee_addr     <= 24'h000000;
      ee_lat_data <= 16'h0000;
    end
    else
    begin
      // No commit when a reset event lands on the last cycle
      ee_commit   <= tmr_done && !abort_evt;
      ee_lat_data <= latch_mem[ee_lat_idx];
      if (start_req)
      begin
        ee_op <= op_code;
        // Block ops are aligned to the 32-byte latch row
        if (op_code == `EEWS_OP_BLK_PGM || op_code == `EEWS_OP_BLK_ERS)
          ee_addr <= {target_addr_high, target_addr_low[15:5], 5'h00};
        else
          ee_addr <= {target_addr_high, target_addr_low};
      end
    end
  end

  // Table reads: array is mid-cycle, so data is not trustworthy
  // Returning a fixed filler rather than the raw array bus keeps a
  // half-written cell from ever looking like valid data.
  always @(posedge mclk)
  begin
    if (rst)
      tr_data <= 16'h0000;
    else if (start_bit)
      tr_data <= `EEWS_RD_JUNK;
    else
      tr_data <= ee_rd_raw;
  end

  // Register read data, one cycle after the strobe; key reads as zero
  // Read data return to zero outside the answer cycle, so a stale value
  // cannot be mistaken for a fresh one. The key register is write-only
  // so that the unlock values cannot be read back by stray code.
  always @(posedge mclk)
  begin
    if (rst)
      reg_rdata <= 16'h0000;
    else if (reg_rd)
    begin
      case (reg_addr)
        `EEWS_OFS_CTRL:    reg_rdata <= ctrl_val;
        `EEWS_OFS_ADDR_LO: reg_rdata <= target_addr_low;
        `EEWS_OFS_ADDR_HI: reg_rdata <= {8'h00, target_addr_high};
        `EEWS_OFS_STATUS:  reg_rdata <= {14'h0000, tmr_busy, done_flag};
        default:           reg_rdata <= 16'h0000;
      endcase
    end
    else
      reg_rdata <= 16'h0000;
  end

  // Limitations: the engine does not check that a word was erased before
  // it is programmed, and it does not time the power-up delay itself; the
  // power-up timer arrives as a level from the reset block.

endmodule

// file: verilog/eews_unlock.v
// Unlock key sequence tracker
`timescale 1ns/10ps
`include "eews_regs.vh"
module eews_unlock
(
  // Clock and reset
  input  wire       mclk,
  input  wire       rst,
  // Key register writes
  input  wire       key_wr,
  input  wire [7:0] key_data,
  // Any write to the control register consumes the unlock
  input  wire       ctrl_wr,
  // Unlock held
  output wire       armed
);

  localparam [1:0] ST_IDLE  = 2'd0; // No key seen
  localparam [1:0] ST_FIRST = 2'd1; // First key seen
  localparam [1:0] ST_ARMED = 2'd2; // Both keys seen

  reg [1:0] state;      // Sequence state
  reg [1:0] next_state; // Next sequence state

  assign armed = (state == ST_ARMED);

  // Next state; any out-of-order key write falls back to idle
  always @*
  begin
    next_state = state;
    if (ctrl_wr)
      next_state = ST_IDLE;
    else if (key_wr)
    begin
      case (state)
        ST_IDLE:
          next_state = (key_data == `EEWS_KEY_FIRST) ? ST_FIRST : ST_IDLE;
        ST_FIRST:
          next_state = (key_data == `EEWS_KEY_SECOND) ? ST_ARMED : ST_IDLE;
        default:
          next_state = ST_IDLE;
      endcase
    end
  end

  // State register
  always @(posedge mclk)
  begin
    if (rst)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

endmodule
